// File: src/usb_pipe_response_control.sv
module usb_pipe_response_control
    import usb_pipe_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // protocol engine events, one bit per bulk pipe (bit 0 pipe A, bit 1 pipe B), except the single shared busReset and frameTick
    input wire logic [1:0] tokenSeen,
    input wire logic [1:0] txnStart,
    input wire logic [1:0] txnEnd,
    input wire logic [1:0] txnOk,
    input wire logic [1:0] pidMismatch,
    input wire logic [1:0] overSize,
    input wire logic [1:0] transferEnd,
    input wire logic [1:0] rxError,
    input wire logic [1:0] stallSeen,
    input wire logic [1:0] planeWritten,
    input wire logic [1:0] planeSent,
    input wire logic [1:0] bufAccess,
    input wire logic busReset,
    input wire logic frameTick,
    // answers toward the protocol engine and buffer
    output reply_type replyA,
    output reply_type replyB,
    output logic [1:0] tokenEnable,
    output logic [1:0] expectData1,
    output logic [1:0] bufferClear,
    output logic [1:0] notReadyIrq,
    output logic [1:0] bufIrqMask,
    output logic intervalError
);

    logic ackReg;
    logic [31:0] rdataReg;
    logic [2:0] iitvReg;
    logic rsvReg;
    logic hostReg;
    logic [1:0] dirReg;
    logic [1:0] disEndReg;
    logic [2:0] pselReg;
    pid_type pidReg [2];
    logic [1:0] toggleReg;
    logic [1:0] aclrReg;
    logic [1:0] atrepReg;
    logic [1:0] busyReg;
    logic [1:0] errCnt [2];
    logic [1:0] planeCnt [2];
    logic [1:0] clearReg;
    logic [1:0] nrdyReg;
    logic [6:0] frameCnt;
    logic intervalReg;

    logic access;
    logic wrEn;
    logic [13:0] index;
    logic [1:0] pipeWr;

    // a request is taken once; ack lasts one cycle so the master must drop stb
    assign access = wb_cyc_i & wb_stb_i & ~ackReg;
    assign wrEn = access & wb_we_i;
    assign index = wb_adr_i[15:2];
    assign pipeWr[0] = wrEn & (index == PIPE_A_IDX); // RULE22
    assign pipeWr[1] = wrEn & (index == PIPE_B_IDX); // RULE22

    // expected reply on a token while acting as peripheral
    function automatic reply_type replyOf(input pid_type response_code, input logic atrep,
                                          input logic dir);
        reply_type r;
        r = REPLY_NAK;
        unique case (response_code)
            PID_NAK: r = REPLY_NAK; // RULE4 RULE24
            PID_BUF: begin
                if (atrep) begin
                    r = dir ? REPLY_ZLP : REPLY_NAK; // RULE19 RULE20
                end else begin
                    r = REPLY_DATA; // RULE4
                end
            end
            PID_STALL_W, PID_STALL: r = REPLY_STALL; // RULE4
        endcase
        return r;
    endfunction

    // control register readback; reserved bits read as zero
    function automatic logic [15:0] pipeView(input int p);
        logic [15:0] v;
        v = 16'h0000;
        v[PID_LSB +: 2] = pidReg[p];
        v[BUSY_BIT] = busyReg[p];
        v[TMON_BIT] = toggleReg[p];
        v[ACLR_BIT] = aclrReg[p];
        v[ATREP_BIT] = atrepReg[p];
        // receiving pipes mirror buffer status in the monitor bit
        v[TXMON_BIT] = dirReg[p] ? (planeCnt[p] != 2'h0) : bufAccess[p]; // RULE21
        v[BUFFER_ACCESS_STATUS_BIT] = bufAccess[p]; // RULE21
        return v;
    endfunction

    // host mode only issues tokens from buffer mode
    assign replyA = hostReg ? REPLY_NAK : replyOf(pidReg[0], atrepReg[0], dirReg[0]);
    assign replyB = hostReg ? REPLY_NAK : replyOf(pidReg[1], atrepReg[1], dirReg[1]);
    assign tokenEnable[0] = hostReg & (pidReg[0] == PID_BUF);
    assign tokenEnable[1] = hostReg & (pidReg[1] == PID_BUF);
    assign expectData1 = toggleReg;
    assign bufferClear = clearReg;
    assign notReadyIrq = nrdyReg;
    assign intervalError = intervalReg;
    // auto response in buffer mode keeps buffer-ready and buffer-empty quiet
    assign bufIrqMask[0] = atrepReg[0] & (pidReg[0] == PID_BUF); // RULE19
    assign bufIrqMask[1] = atrepReg[1] & (pidReg[1] == PID_BUF); // RULE19

    // bus answer: one wait state, unmapped reads give zero and writes drop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ackReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
        end else begin
            ackReg <= access;
            if (access & ~wb_we_i) begin
                unique case (index)
                    INTERVAL_IDX: begin
                        rdataReg <= {16'h0000, 3'h0, rsvReg, 9'h000, iitvReg};
                    end
                    PIPE_A_IDX: rdataReg <= {16'h0000, pipeView(0)}; // RULE22
                    PIPE_B_IDX: rdataReg <= {16'h0000, pipeView(1)}; // RULE22
                    CONFIG_IDX: begin
                        rdataReg <= {24'h0000_00, pselReg, disEndReg, dirReg, hostReg};
                    end
                    default: rdataReg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = rdataReg;

    // interval and configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            iitvReg <= INTERVAL_EXPONENT_RESET;
            rsvReg <= 1'b0;
            hostReg <= 1'b0;
            dirReg <= 2'b00;
            disEndReg <= 2'b00;
            pselReg <= PSEL_RESET;
        end else begin
            if (wrEn & (index == INTERVAL_IDX)) begin
                if (wb_sel_i[0]) begin
                    iitvReg <= wb_dat_i[INTERVAL_EXPONENT_LSB +: 3];
                end
                if (wb_sel_i[1]) begin
                    rsvReg <= wb_dat_i[INTERVAL_EXPONENT_RSV_BIT];
                end
            end
            if (wrEn & (index == CONFIG_IDX) & wb_sel_i[0]) begin
                hostReg <= wb_dat_i[HOST_BIT];
                dirReg <= {wb_dat_i[DIR_B_BIT], wb_dat_i[DIR_A_BIT]};
                disEndReg <= {wb_dat_i[DISEND_B_BIT], wb_dat_i[DISEND_A_BIT]};
                pselReg <= wb_dat_i[PSEL_LSB +: 3];
            end
        end
    end

    // response code: hardware events win over a software write in the same cycle
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                pidReg[p] <= PID_NAK; // RULE5
            end else if (overSize[p]) begin
                pidReg[p] <= PID_STALL; // RULE7
            end else if (hostReg & stallSeen[p]) begin
                pidReg[p] <= PID_STALL; // RULE10
            end else if (~hostReg & busReset) begin
                pidReg[p] <= PID_NAK; // RULE8
            end else if (hostReg & rxError[p] & (errCnt[p] == ERR_LIMIT)) begin
                pidReg[p] <= PID_NAK; // RULE9
            end else if (~dirReg[p] & disEndReg[p] & transferEnd[p]) begin
                pidReg[p] <= PID_NAK; // RULE6
            end else if (pipeWr[p] & wb_sel_i[0]) begin
                // stall entry and exit codes are stored as written
                pidReg[p] <= pid_type'(wb_dat_i[PID_LSB +: 2]); // RULE11
            end
        end
    end

    // consecutive receive errors; any good completion restarts the count
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                errCnt[p] <= 2'h0;
            end else if (txnOk[p] | ~hostReg) begin
                errCnt[p] <= 2'h0;
            end else if (rxError[p]) begin
                errCnt[p] <= (errCnt[p] == ERR_LIMIT) ? 2'h0 : errCnt[p] + 2'h1; // RULE9
            end
        end
    end

    // busy flag spans one transaction; a start in the end cycle keeps it up
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                busyReg[p] <= 1'b0;
            end else if (txnStart[p]) begin
                busyReg[p] <= 1'b1; // RULE12
            end else if (txnEnd[p]) begin
                busyReg[p] <= 1'b0; // RULE12
            end
        end
    end

    // sequence toggle; software strobes are trusted only at NAK so they take priority
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                toggleReg[p] <= 1'b0;
            end else if (pipeWr[p] & wb_sel_i[1] & wb_dat_i[TCLR_BIT]) begin
                toggleReg[p] <= 1'b0; // RULE16 RULE13
            end else if (pipeWr[p] & wb_sel_i[0] & wb_dat_i[TSET_BIT]) begin
                toggleReg[p] <= 1'b1; // RULE16
            end else if (txnOk[p] & ~(pidMismatch[p] & ~dirReg[p])) begin
                // auto response IN completes on host ACK, which is also txnOk
                toggleReg[p] <= ~toggleReg[p]; // RULE15 RULE19
            end
        end
    end

    // auto clear and auto response bits; clear pulses on the 1-to-0 write
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                aclrReg[p] <= 1'b0;
                atrepReg[p] <= 1'b0;
                clearReg[p] <= 1'b0;
            end else begin
                clearReg[p] <= 1'b0;
                if (pipeWr[p] & wb_sel_i[1]) begin
                    aclrReg[p] <= wb_dat_i[ACLR_BIT]; // RULE14
                    atrepReg[p] <= wb_dat_i[ATREP_BIT]; // RULE18
                    clearReg[p] <= aclrReg[p] & ~wb_dat_i[ACLR_BIT]; // RULE17
                end
            end
        end
    end

    // not-ready pulse for auto response OUT tokens
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                nrdyReg[p] <= 1'b0;
            end else begin
                nrdyReg[p] <= ~hostReg & atrepReg[p] & ~dirReg[p] &
                              (pidReg[p] == PID_BUF) & tokenSeen[p]; // RULE20
            end
        end
    end

    // written-plane count; clamps so a late write cannot wrap the monitor
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (sys_rst) begin
                planeCnt[p] <= 2'h0;
            end else if (clearReg[p] | ~dirReg[p]) begin
                planeCnt[p] <= 2'h0; // RULE17
            end else if (planeWritten[p] & ~planeSent[p]) begin
                if (planeCnt[p] != PLANES_MAX) begin
                    planeCnt[p] <= planeCnt[p] + 2'h1; // RULE23
                end
            end else if (planeSent[p] & ~planeWritten[p]) begin
                if (planeCnt[p] != 2'h0) begin
                    planeCnt[p] <= planeCnt[p] - 2'h1; // RULE23
                end
            end
        end
    end

    // interval timer for the interrupt pipes; restarted by any buffer clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frameCnt <= 7'h00;
            intervalReg <= 1'b0;
        end else begin
            intervalReg <= 1'b0;
            if ((clearReg != 2'b00) | (pselReg < PSEL_FIRST_INTR)) begin
                frameCnt <= 7'h00; // RULE2 RULE3
            end else if (frameTick) begin
                if (frameCnt == 7'((1 << iitvReg) - 1)) begin
                    frameCnt <= 7'h00;
                    intervalReg <= 1'b1; // RULE1
                end else begin
                    frameCnt <= frameCnt + 7'h01;
                end
            end
        end
    end

endmodule

// File: pkg/usb_pipe_pkg.sv
// Overview of operation
// [RULE1] interval field sets error detection period of two to the field power frames
// [RULE2] software forces NAK then pulses auto buffer clear before changing interval
// [RULE3] interval field is ignored for bulk pipes; software keeps it zero there
// [RULE4] response code 00 is NAK, 01 buffer dependent, 10 and 11 STALL
// [RULE5] response code resets to NAK; software selects buffer mode before use
// [RULE6] receiving pipe with disable-at-end goes to NAK when transfer completes
// [RULE7] oversize data packet sets response code to 11 STALL
// [RULE8] as peripheral, USB bus reset sets response code to NAK
// [RULE9] as host, three consecutive receive errors set response code to NAK
// [RULE10] as host, a received STALL handshake sets response code to 11
// [RULE11] software enters and leaves STALL only through the documented code sequences
// [RULE12] busy flag rises at transaction start and falls when it completes
// [RULE13] software changes auto response or toggle strobes only while code is NAK
// [RULE14] software changes auto buffer clear only at NAK, before port selection
// [RULE15] toggle monitor shows expected DATA0/1; flips on good completion, not on mismatch; code still flips on mismatch for transmit pipes
// [RULE16] toggle set strobe gives DATA1, clear strobe gives DATA0; both read zero
// [RULE17] writing 1 then 0 to auto buffer clear discards the pipe's buffer
// [RULE18] software enables auto response only as peripheral on a bulk pipe
// [RULE19] auto response bulk IN answers zero-length packets, toggles on ACK, no buffer irqs
// [RULE20] auto response bulk OUT answers NAK and raises the not-ready interrupt
// [RULE21] transmit monitor shows unsent data; buffer status shows processor access allowed
// [RULE22] each pipe control register is reached at its own address, any selection
// [RULE23] transmit monitor sets once a plane is written, clears when planes are sent
// [RULE24] as peripheral at NAK every bulk or interrupt token gets a NAK handshake
package usb_pipe_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] INTERVAL_IDX = 14'h2e6e;
    localparam logic [13:0] PIPE_A_IDX = 14'h2e76;
    localparam logic [13:0] PIPE_B_IDX = 14'h2e78;
    localparam logic [13:0] CONFIG_IDX = 14'h2e80;

    // pipe control field positions
    localparam int PID_LSB = 0;
    localparam int BUSY_BIT = 5;
    localparam int TMON_BIT = 6;
    localparam int TSET_BIT = 7;
    localparam int TCLR_BIT = 8;
    localparam int ACLR_BIT = 9;
    localparam int ATREP_BIT = 10;
    localparam int TXMON_BIT = 14;
    localparam int BUFFER_ACCESS_STATUS_BIT = 15;

    // interval register fields
    localparam int INTERVAL_EXPONENT_LSB = 0;
    localparam int INTERVAL_EXPONENT_RSV_BIT = 12;

    // configuration register fields
    localparam int HOST_BIT = 0;
    localparam int DIR_A_BIT = 1;
    localparam int DIR_B_BIT = 2;
    localparam int DISEND_A_BIT = 3;
    localparam int DISEND_B_BIT = 4;
    localparam int PSEL_LSB = 5;

    // reset values
    localparam logic [2:0] INTERVAL_EXPONENT_RESET = 3'h0;
    localparam logic [2:0] PSEL_RESET = 3'h0;
    localparam logic [2:0] PSEL_FIRST_INTR = 3'h6;
    localparam logic [1:0] ERR_LIMIT = 2'h2;
    localparam logic [1:0] PLANES_MAX = 2'h2;

    typedef enum logic [1:0] {
        PID_NAK = 2'b00,
        PID_BUF = 2'b01,
        PID_STALL_W = 2'b10,
        PID_STALL = 2'b11
    } pid_type;

    typedef enum logic [1:0] {
        REPLY_NAK = 2'b00,
        REPLY_DATA = 2'b01,
        REPLY_STALL = 2'b10,
        REPLY_ZLP = 2'b11
    } reply_type;

endpackage

// File: tb/usb_pipe_response_control_monitor.sv
module usb_pipe_response_control_monitor
    import usb_pipe_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] tokenSeen,
    input wire logic [1:0] txnOk,
    input wire logic [1:0] pidMismatch,
    input wire logic [1:0] overSize,
    input wire logic [1:0] stallSeen,
    input wire logic busReset,
    input wire reply_type replyA,
    input wire reply_type replyB,
    input wire logic [1:0] tokenEnable,
    input wire logic [1:0] expectData1,
    input wire logic [1:0] bufferClear,
    input wire logic [1:0] notReadyIrq,
    input wire logic [1:0] bufIrqMask
);
    timeunit 1ns;
    timeprecision 1ns;
    // one clock domain, so one clocking and one reset serve every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a request the slave has not answered yet
    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // a clean completion with no register write that could move the toggle
    sequence goodDone;
        txnOk[0] && !pidMismatch[0] && !(wb_cyc_i && wb_stb_i && wb_we_i);
    endsequence
    // token on a receive pipe that auto response is holding off
    sequence autoOutToken;
        tokenSeen[0] && bufIrqMask[0] && replyA == REPLY_NAK;
    endsequence
    chk_ack_next_cycle: assert property (reqTaken |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    chk_reset_nak: assert property ($fell(sys_rst) |-> !wb_ack_o && replyA == REPLY_NAK
        && replyB == REPLY_NAK && expectData1 == 2'b00)
        else $error("state not cleared by reset");
    chk_oversize_stall: assert property (overSize[0] |=> !tokenEnable[0]
        && !(replyA inside {REPLY_DATA, REPLY_ZLP}))
        else $error("oversize packet did not stop the pipe");
    chk_host_stall: assert property (stallSeen[0] |=> !tokenEnable[0])
        else $error("stall handshake left tokens enabled");
    chk_bus_reset_nak: assert property (busReset |=> !(replyA inside {REPLY_DATA, REPLY_ZLP})
        && !(replyB inside {REPLY_DATA, REPLY_ZLP}))
        else $error("bus reset left a pipe answering data");
    chk_toggle_flip: assert property (goodDone |=> $changed(expectData1[0]))
        else $error("toggle did not flip on completion");
    chk_toggle_hold: assert property (txnOk[0] && pidMismatch[0]
        && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(expectData1[0]))
        else $error("toggle flipped on data pid mismatch");
    chk_auto_reply: assert property (bufIrqMask[0] |-> replyA inside {REPLY_ZLP, REPLY_NAK})
        else $error("auto response reply wrong");
    chk_not_ready: assert property (autoOutToken |=> notReadyIrq[0] ##1 !notReadyIrq[0])
        else $error("not ready interrupt missing after token");
    chk_clear_pulse: assert property (bufferClear[0] |=> !bufferClear[0])
        else $error("buffer clear longer than one cycle");
    chk_host_token: assert property (tokenEnable[0] |-> replyA == REPLY_NAK)
        else $error("host pipe answering as peripheral");
endmodule

bind usb_pipe_response_control usb_pipe_response_control_monitor mon (.clock(clock),
    .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .tokenSeen(tokenSeen), .txnOk(txnOk), .pidMismatch(pidMismatch),
    .overSize(overSize), .stallSeen(stallSeen), .busReset(busReset), .replyA(replyA),
    .replyB(replyB), .tokenEnable(tokenEnable), .expectData1(expectData1),
    .bufferClear(bufferClear), .notReadyIrq(notReadyIrq), .bufIrqMask(bufIrqMask));

// File: tb/usb_bus_partner_model.sv
module usb_bus_partner_model (
    input wire logic clock,
    input wire logic [1:0] go,
    input wire logic slow,
    input wire logic bad,
    input wire logic refused,
    output logic [1:0] tokenSeen = 2'b00,
    output logic [1:0] txnStart = 2'b00,
    output logic [1:0] txnEnd = 2'b00,
    output logic [1:0] txnOk = 2'b00,
    output logic [1:0] pidMismatch = 2'b00
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pipeReg = 2'b00;
    logic [2:0] countReg = 3'h0;
    // one transaction at a time; a refused one ends without a good completion
    always @(posedge clock) begin
        tokenSeen <= 2'b00;
        txnStart <= 2'b00;
        txnEnd <= 2'b00;
        txnOk <= 2'b00;
        pidMismatch <= 2'b00;
        if (countReg != 3'h0) begin
            countReg <= countReg - 3'h1;
            if (countReg == 3'h1) begin
                txnEnd <= pipeReg;
                txnOk <= refused ? 2'b00 : pipeReg;
                pidMismatch <= bad ? pipeReg : 2'b00;
            end
        end else if (go != 2'b00) begin
            tokenSeen <= go;
            txnStart <= go;
            pipeReg <= go;
            countReg <= slow ? 3'h6 : 3'h1; // slow gap lets the busy flag be read
        end
    end
endmodule

// File: tb/usb_pipe_response_control_bench.sv
module usb_pipe_response_control_bench
    import usb_pipe_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [13:0] idx;
        logic [15:0] wr;
        logic [15:0] exp;
    } row_type;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] datIn = 32'h0000_0000;
    logic [13:0] evt = 14'h0000;
    logic [1:0] bufAcc = 2'b00;
    logic [1:0] go = 2'b00;
    logic slow = 1'b0;
    logic bad = 1'b0;
    logic refused = 1'b0;
    logic [31:0] datOut;
    logic ack, ivErr;
    logic [1:0] tokSeen, txStart, txEnd, txOk, pidMis, tokEn, expD1, bufClr, nrIrq, irqMask;
    reply_type replyA, replyB;
    logic [15:0] q;
    int failures = 0;
    int testsRun = 0;
    int nrCount = 0;
    int clrCount = 0;
    int ivCount = 0;
    int i;
    row_type rows [7] = '{'{PIPE_A_IDX, 16'h0080, 16'h0040}, '{PIPE_A_IDX, 16'h0100, 16'h0000},
        '{PIPE_A_IDX, 16'h0181, 16'h0001}, '{PIPE_B_IDX, 16'h0402, 16'h0402},
        '{PIPE_B_IDX, 16'h0000, 16'h0000}, '{INTERVAL_IDX, 16'hffff, 16'h1007},
        '{14'h2e81, 16'hffff, 16'h0000}};

    usb_bus_partner_model partner (.clock(clock), .go(go), .slow(slow), .bad(bad),
        .refused(refused), .tokenSeen(tokSeen), .txnStart(txStart), .txnEnd(txEnd),
        .txnOk(txOk), .pidMismatch(pidMis));
    usb_pipe_response_control dut (.clock(clock), .sys_rst(sysRst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(datIn),
        .wb_dat_o(datOut), .wb_ack_o(ack), .tokenSeen(tokSeen), .txnStart(txStart),
        .txnEnd(txEnd), .txnOk(txOk), .pidMismatch(pidMis), .overSize(evt[1:0]),
        .transferEnd(evt[3:2]), .rxError(evt[5:4]), .stallSeen(evt[7:6]),
        .planeWritten(evt[9:8]), .planeSent(evt[11:10]), .bufAccess(bufAcc),
        .busReset(evt[12]), .frameTick(evt[13]), .replyA(replyA), .replyB(replyB),
        .tokenEnable(tokEn), .expectData1(expD1), .bufferClear(bufClr),
        .notReadyIrq(nrIrq), .bufIrqMask(irqMask), .intervalError(ivErr));

    // 25 MHz
    initial forever #20 clock = ~clock;

    // pulse outputs are counted so a scenario can compare totals afterwards
    always @(posedge clock) begin
        if (nrIrq[0] === 1'b1) nrCount++;
        if (bufClr[0] === 1'b1) clrCount++;
        if (ivErr === 1'b1) ivCount++;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then release
    task wbAccess(input logic w, input logic [13:0] idx, input logic [15:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        datIn <= {16'h0000, d};
        // no wait-state count is assumed; a missing ack is left to the watchdog
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = datOut[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wr(input logic [13:0] idx, input logic [15:0] d);
        wbAccess(1'b1, idx, d);
    endtask

    task rdChk(input logic [13:0] idx, input logic [15:0] exp);
        wbAccess(1'b0, idx, 16'h0000);
        check(q, exp);
    endtask

    task pulse(input logic [13:0] m);
        @(posedge clock);
        evt <= m;
        @(posedge clock);
        evt <= 14'h0000;
    endtask

    task goPipe(input logic [1:0] p);
        @(posedge clock);
        go <= p;
        @(posedge clock);
        go <= 2'b00;
    endtask

    task txn(input logic [1:0] p);
        goPipe(p);
        repeat (10) @(posedge clock);
    endtask

    task print_verdict;
        if (failures == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the whole sequence takes a few hundred cycles, so this only catches a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        print_verdict;
    end

    initial begin
        repeat (8) @(posedge clock);
        sysRst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            wr(rows[i].idx, rows[i].wr);
            rdChk(rows[i].idx, rows[i].exp);
        end
        // second reset in mid-run with a pipe live
        @(posedge clock);
        sysRst <= 1'b1;
        repeat (2) @(posedge clock);
        sysRst <= 1'b0;
        rdChk(PIPE_A_IDX, 16'h0000);
        rdChk(INTERVAL_IDX, 16'h0000);
        // peripheral, pipe A receive with disable-at-end
        wr(CONFIG_IDX, 16'h0008);
        wr(PIPE_A_IDX, 16'h0001);
        pulse(14'h0004);
        rdChk(PIPE_A_IDX, 16'h0000);
        wr(PIPE_A_IDX, 16'h0001);
        pulse(14'h0001);
        rdChk(PIPE_A_IDX, 16'h0003);
        check({14'h0000, replyA}, 16'h0002);
        wr(PIPE_B_IDX, 16'h0001);
        check({14'h0000, replyB}, 16'h0001);
        pulse(14'h1000);
        rdChk(PIPE_B_IDX, 16'h0000);
        wr(PIPE_A_IDX, 16'h0002);
        wr(PIPE_A_IDX, 16'h0000);
        // slow transaction shows busy, then toggle rules
        slow <= 1'b1;
        goPipe(2'b01);
        rdChk(PIPE_A_IDX, 16'h0020);
        repeat (8) @(posedge clock);
        rdChk(PIPE_A_IDX, 16'h0040);
        bad <= 1'b1;
        txn(2'b01);
        bad <= 1'b0;
        slow <= 1'b0;
        rdChk(PIPE_A_IDX, 16'h0040);
        txn(2'b01);
        rdChk(PIPE_A_IDX, 16'h0000);
        // host: errors counted only when consecutive, then a stall
        wr(CONFIG_IDX, 16'h0001);
        wr(PIPE_A_IDX, 16'h0001);
        check({14'h0000, tokEn}, 16'h0001);
        pulse(14'h0010);
        pulse(14'h0010);
        txn(2'b01);
        pulse(14'h0010);
        pulse(14'h0010);
        rdChk(PIPE_A_IDX, 16'h0041);
        pulse(14'h0010);
        rdChk(PIPE_A_IDX, 16'h0040);
        wr(PIPE_A_IDX, 16'h0001);
        pulse(14'h0040);
        rdChk(PIPE_A_IDX, 16'h0043);
        wr(PIPE_A_IDX, 16'h0002);
        wr(PIPE_A_IDX, 16'h0000);
        // peripheral auto response: pipe B transmit, pipe A receive
        wr(CONFIG_IDX, 16'h0004);
        wr(PIPE_B_IDX, 16'h0400);
        wr(PIPE_B_IDX, 16'h0401);
        check({14'h0000, replyB}, 16'h0003);
        check({14'h0000, irqMask}, 16'h0002);
        txn(2'b10);
        rdChk(PIPE_B_IDX, 16'h0441);
        wr(PIPE_A_IDX, 16'h0400);
        wr(PIPE_A_IDX, 16'h0401);
        i = nrCount;
        refused <= 1'b1;
        txn(2'b01);
        refused <= 1'b0;
        check(16'(nrCount - i), 16'h0001);
        bufAcc <= 2'b10;
        pulse(14'h0200);
        rdChk(PIPE_B_IDX, 16'hc441);
        pulse(14'h0800);
        rdChk(PIPE_B_IDX, 16'h8441);
        // buffer clear at NAK, which also restarts the interval timer
        wr(PIPE_A_IDX, 16'h0000);
        i = clrCount;
        wr(PIPE_A_IDX, 16'h0200);
        wr(PIPE_A_IDX, 16'h0000);
        repeat (2) @(posedge clock);
        check(16'(clrCount - i), 16'h0001);
        // exponent 2 on an interrupt pipe: one error every four frames
        wr(CONFIG_IDX, 16'h00c0);
        wr(INTERVAL_IDX, 16'h0002);
        i = ivCount;
        repeat (8) pulse(14'h2000);
        repeat (3) @(posedge clock);
        check(16'(ivCount - i), 16'h0002);
        print_verdict;
    end
endmodule
